// file: mpom_top.v
// motor phase output manager: window generator and six-channel manager
`timescale 1ns/1ps
`include "mpom_map.vh"

module mpom_top #(
    // output reset state option: hiz, low or high
    parameter [1:0] RESET_STATE = `MPOM_RST_HIZ
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // mode configuration
    input wire current_mode_i,
    input wire sensor_mode_bit_i,
    input wire on_time_sampling_bit_i,
    input wire [3:0] sample_delay_field_i,
    input wire [3:0] window_rate_select_i,
    input wire [3:0] min_off_time_select_i,
    // channel configuration
    input wire [5:0] channel_on_off_preload_i,
    input wire preload_wr_i,
    input wire [5:0] channel_polarity_i,
    input wire [5:0] parity_group_i,
    input wire z_to_c_pwm_steer_i,
    input wire d_to_z_pwm_steer_i,
    input wire demag_pwm_steer_i,
    // control bits
    input wire direct_access_i,
    input wire clock_enable_i,
    input wire main_output_enable_set_i,
    input wire main_output_enable_clr_i,
    input wire emergency_irq_mask_i,
    input wire emergency_flag_clr_i,
    // step events from the motor timer logic
    input wire comm_event_i,
    input wire demag_event_i,
    input wire zero_cross_event_i,
    // pins from outside the clock domain
    input wire voltage_pwm_i,
    input wire current_cmp_i,
    input wire emergency_stop_n_i,
    // motor outputs
    output reg [5:0] motor_output_o,
    output reg [5:0] motor_output_oe_n_o,
    // status
    output reg main_output_enable_o,
    output reg emergency_flag_o,
    output reg emergency_irq_o,
    output reg motor_timer_clk_en_o,
    output reg measurement_window_o,
    output reg zc_detect_window_o,
    output reg [5:0] phase_o,
    output reg [1:0] step_state_o
);

    // output values under reset or emergency, fixed by the option
    localparam [5:0] RST_VAL =
        (RESET_STATE == `MPOM_RST_HIGH) ? `MPOM_CH_ONES : `MPOM_CH_ZERO;
    localparam [5:0] RST_OE_N =
        (RESET_STATE == `MPOM_RST_HIZ) ? `MPOM_CH_ONES : `MPOM_CH_ZERO;

    // peripheral tick
    reg [`MPOM_DIV_W-1:0] div_ff;
    reg tick_ff;

    // pin synchronisers
    reg vpwm_s1_ff;
    reg vpwm_s2_ff;
    reg cmp_s1_ff;
    reg cmp_s2_ff;
    reg emg_s1_ff;
    reg emg_s2_ff;
    reg emg_s3_ff;

    // channel state
    reg [5:0] preload_ff;
    reg [5:0] phase_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg demag_steer_ff;
    reg moe_ff;
    reg flag_ff;
    reg steer;
    reg pwm_src;

    wire comm_ev;
    wire d_ev;
    wire z_ev;
    wire force_zero;
    wire win;
    wire cur_pwm;
    wire emg_fall;
    wire [5:0] nxt_out;
    wire [5:0] nxt_oe_n;

    // peripheral tick at the 4 MHz reference rate
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= {`MPOM_DIV_W{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            if (div_ff == `MPOM_PERIPH_DIV - 1) begin
                div_ff <= {`MPOM_DIV_W{1'b0}};
                tick_ff <= 1'b1;
            end else begin
                div_ff <= div_ff + 8'h01;
                tick_ff <= 1'b0;
            end
        end
    end

    // two-stage synchronisers; emergency gets a third stage for edges
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            vpwm_s1_ff <= 1'b0;
            vpwm_s2_ff <= 1'b0;
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            emg_s1_ff <= 1'b1;
            emg_s2_ff <= 1'b1;
            emg_s3_ff <= 1'b1;
        end else begin
            vpwm_s1_ff <= voltage_pwm_i;
            vpwm_s2_ff <= vpwm_s1_ff;
            cmp_s1_ff <= current_cmp_i;
            cmp_s2_ff <= cmp_s1_ff;
            emg_s1_ff <= emergency_stop_n_i;
            emg_s2_ff <= emg_s1_ff;
            emg_s3_ff <= emg_s2_ff;
        end
    end

    assign emg_fall = emg_s3_ff && !emg_s2_ff;

    // sensor mode, sampling during on time or a nonzero sample delay removes the minimum off time
    assign force_zero = sensor_mode_bit_i || on_time_sampling_bit_i ||
        (sample_delay_field_i != 4'h0);

    mpom_window_gen u_win (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(tick_ff),
        .window_rate_select_i(window_rate_select_i),
        .min_off_time_select_i(min_off_time_select_i),
        .force_zero_off_i(force_zero),
        .cur_limit_i(cmp_s2_ff),
        .window_o(win),
        .pwm_o(cur_pwm)
    );

    // commutation: external event, or preload write in direct access
    assign comm_ev = direct_access_i ? preload_wr_i : comm_event_i;
    assign d_ev = demag_event_i && !direct_access_i;
    assign z_ev = zero_cross_event_i && !direct_access_i;

    // preload and phase registers
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            preload_ff <= `MPOM_CH_ZERO;
            phase_ff <= `MPOM_CH_ZERO;
            demag_steer_ff <= 1'b0;
        end else begin
            if (preload_wr_i) begin
                preload_ff <= channel_on_off_preload_i;
            end
            if (comm_ev) begin
                // a write in the same cycle as the event is taken at once
                if (preload_wr_i) begin
                    phase_ff <= channel_on_off_preload_i;
                end else begin
                    phase_ff <= preload_ff;
                end
                demag_steer_ff <= demag_pwm_steer_i;
            end
        end
    end

    // step state: demag after commutation, then d-to-z, then z-to-c
    always @* begin
        nxt_state = state_ff;
        if (comm_ev) begin
            nxt_state = `MPOM_ST_DEMAG;
        end else begin
            case (state_ff)
                `MPOM_ST_DEMAG: begin
                    if (d_ev) begin
                        nxt_state = `MPOM_ST_D2Z;
                    end
                end
                `MPOM_ST_D2Z: begin
                    if (z_ev) begin
                        nxt_state = `MPOM_ST_Z2C;
                    end
                end
                `MPOM_ST_Z2C: begin
                    nxt_state = `MPOM_ST_Z2C;
                end
                default: begin
                    nxt_state = state_ff;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= `MPOM_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // steering bit for the current step; 0 high group, 1 low group
    always @* begin
        if (direct_access_i) begin
            steer = z_to_c_pwm_steer_i;
        end else begin
            case (state_ff)
                `MPOM_ST_DEMAG: steer = demag_steer_ff;
                `MPOM_ST_D2Z: steer = d_to_z_pwm_steer_i;
                `MPOM_ST_Z2C: steer = z_to_c_pwm_steer_i;
                default: steer = z_to_c_pwm_steer_i;
            endcase
        end
    end

    // pwm source: window-shaped in current mode, generator otherwise
    always @* begin
        if (current_mode_i) begin
            pwm_src = cur_pwm;
        end else begin
            pwm_src = vpwm_s2_ff;
        end
    end

    // per-channel output level
    genvar gi;
    generate
        for (gi = 0; gi < `MPOM_NCH; gi = gi + 1) begin : g_ch
            wire grp_hit;
            wire pwm_on;
            // channel takes pwm when its group matches the steering
            assign grp_hit = (parity_group_i[gi] == steer);
            assign pwm_on = !grp_hit || pwm_src;
            // on: polarity level while pwm high; off: inverse polarity
            assign nxt_out[gi] = (phase_ff[gi] && pwm_on) ?
                channel_polarity_i[gi] : !channel_polarity_i[gi];
            assign nxt_oe_n[gi] = 1'b0;
        end
    endgenerate

    // main output enable and output stage, forced by emergency async
    always @(posedge sys_clk_i or posedge rst_i or
            negedge emergency_stop_n_i) begin
        if (rst_i) begin
            moe_ff <= 1'b0;
            motor_output_o <= RST_VAL;
            motor_output_oe_n_o <= RST_OE_N;
        end else if (!emergency_stop_n_i) begin
            moe_ff <= 1'b0;
            motor_output_o <= RST_VAL;
            motor_output_oe_n_o <= RST_OE_N;
        end else begin
            if (main_output_enable_set_i) begin
                moe_ff <= 1'b1;
            end else if (main_output_enable_clr_i) begin
                moe_ff <= 1'b0;
            end
            if (moe_ff) begin
                motor_output_o <= nxt_out;
                motor_output_oe_n_o <= nxt_oe_n;
            end else begin
                motor_output_o <= RST_VAL;
                motor_output_oe_n_o <= RST_OE_N;
            end
        end
    end

    // emergency flag: set wins over software clear
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_ff <= 1'b0;
        end else if (emg_fall) begin
            flag_ff <= 1'b1;
        end else if (emergency_flag_clr_i) begin
            flag_ff <= 1'b0;
        end
    end

    // status outputs
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            main_output_enable_o <= 1'b0;
            emergency_flag_o <= 1'b0;
            emergency_irq_o <= 1'b0;
            motor_timer_clk_en_o <= 1'b0;
            measurement_window_o <= 1'b0;
            zc_detect_window_o <= 1'b0;
            phase_o <= `MPOM_CH_ZERO;
            step_state_o <= `MPOM_ST_IDLE;
        end else begin
            main_output_enable_o <= moe_ff;
            emergency_flag_o <= flag_ff;
            emergency_irq_o <= flag_ff && emergency_irq_mask_i;
            motor_timer_clk_en_o <= clock_enable_i && !direct_access_i;
            measurement_window_o <= win;
            zc_detect_window_o <= win && !sensor_mode_bit_i;
            phase_o <= phase_ff;
            step_state_o <= state_ff;
        end
    end

endmodule

// file: mpom_map.vh
// constants for the motor phase output manager
`ifndef MPOM_MAP_VH
`define MPOM_MAP_VH

// peripheral reference: 200 MHz system clock / 4 MHz peripheral tick
`define MPOM_SYS_CLK_MHZ 200
`define MPOM_PERIPH_MHZ 4
`define MPOM_PERIPH_DIV (`MPOM_SYS_CLK_MHZ / `MPOM_PERIPH_MHZ)
`define MPOM_DIV_W 8

// measurement window periods in 4 MHz peripheral ticks
`define MPOM_TICK_W 14
`define MPOM_PER_0 14'd80
`define MPOM_PER_1 14'd100
`define MPOM_PER_2 14'd120
`define MPOM_PER_3 14'd160
`define MPOM_PER_4 14'd200
`define MPOM_PER_5 14'd221
`define MPOM_PER_6 14'd260
`define MPOM_PER_7 14'd320
`define MPOM_PER_8 14'd400
`define MPOM_PER_9 14'd640
`define MPOM_PER_10 14'd1280
`define MPOM_PER_11 14'd2564
`define MPOM_PER_12 14'd3200
`define MPOM_PER_13 14'd4162
`define MPOM_PER_14 14'd6400
`define MPOM_PER_15 14'd10256

// minimum off time: 2.5 us steps, 10 peripheral ticks per step
`define MPOM_OFF_STEP_NS 2500
`define MPOM_OFF_STEP_TICKS 14'd10
`define MPOM_OFF_ZERO 14'd0

// step states
`define MPOM_ST_W 2
`define MPOM_ST_IDLE 2'h0
`define MPOM_ST_DEMAG 2'h1
`define MPOM_ST_D2Z 2'h2
`define MPOM_ST_Z2C 2'h3

// output reset state option codes
`define MPOM_RST_HIZ 2'h0
`define MPOM_RST_LOW 2'h1
`define MPOM_RST_HIGH 2'h2

`define MPOM_NCH 6
`define MPOM_CH_ZERO 6'h00
`define MPOM_CH_ONES 6'h3f

`endif

// file: mpom_window_gen.v
// measurement window generator and current-mode pwm shaping
`timescale 1ns/1ps
`include "mpom_map.vh"

module mpom_window_gen (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // peripheral tick and configuration
    input wire tick_i,
    input wire [3:0] window_rate_select_i,
    input wire [3:0] min_off_time_select_i,
    input wire force_zero_off_i,
    // current comparator, already synchronised
    input wire cur_limit_i,
    // results
    output reg window_o,
    output reg pwm_o
);

    reg [`MPOM_TICK_W-1:0] period;
    reg [`MPOM_TICK_W-1:0] off_ticks;
    reg [`MPOM_TICK_W-1:0] cnt_ff;
    reg [`MPOM_TICK_W-1:0] nxt_cnt;
    reg cl_ff;
    reg nxt_cl;
    wire in_window;
    wire restart;

    always @* begin
        case (window_rate_select_i)
            4'h0: period = `MPOM_PER_0;
            4'h1: period = `MPOM_PER_1;
            4'h2: period = `MPOM_PER_2;
            4'h3: period = `MPOM_PER_3;
            4'h4: period = `MPOM_PER_4;
            4'h5: period = `MPOM_PER_5;
            4'h6: period = `MPOM_PER_6;
            4'h7: period = `MPOM_PER_7;
            4'h8: period = `MPOM_PER_8;
            4'h9: period = `MPOM_PER_9;
            4'ha: period = `MPOM_PER_10;
            4'hb: period = `MPOM_PER_11;
            4'hc: period = `MPOM_PER_12;
            4'hd: period = `MPOM_PER_13;
            4'he: period = `MPOM_PER_14;
            default: period = `MPOM_PER_15;
        endcase
    end

    always @* begin
        if (force_zero_off_i) begin
            off_ticks = `MPOM_OFF_ZERO;
        end else begin
            off_ticks = `MPOM_OFF_STEP_TICKS *
                {{(`MPOM_TICK_W-5){1'b0}}, ({1'b0, min_off_time_select_i}
                + 5'h01)};
        end
    end

    // off time longer than the period means the window never opens
    assign in_window = (off_ticks < period) && (cnt_ff < off_ticks);

    // with no window this period, the period start re-arms the pwm
    assign restart = tick_i && (cnt_ff >= period - 14'd1) &&
        ((off_ticks == `MPOM_OFF_ZERO) || (off_ticks >= period));

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_cl = cl_ff;
        if (tick_i) begin
            if (cnt_ff >= period - 14'd1) begin
                nxt_cnt = {`MPOM_TICK_W{1'b0}};
            end else begin
                nxt_cnt = cnt_ff + 14'd1;
            end
        end
        // limit holds the pwm off until the next window start
        if ((in_window && !window_o) || restart) begin
            nxt_cl = 1'b0;
        end else if (cur_limit_i && !in_window) begin
            nxt_cl = 1'b1;
        end
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= {`MPOM_TICK_W{1'b0}};
            cl_ff <= 1'b0;
            window_o <= 1'b0;
            pwm_o <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            cl_ff <= nxt_cl;
            window_o <= in_window;
            pwm_o <= !in_window && !nxt_cl;
        end
    end

endmodule

// file: mpom_power_stage.sv
// behavioural model of the inverter gate drivers and alarm sources
`timescale 1ns/1ps
module mpom_power_stage (
    // pins from the block
    input wire logic [5:0] motor_output_i,
    input wire logic [5:0] motor_output_oe_n_i,
    // scenario controls
    input wire logic alarm_i,
    input wire logic pwm_level_i,
    input wire logic cmp_level_i,
    // pins into the block
    output wire logic emergency_stop_n_o,
    output wire logic voltage_pwm_o,
    output wire logic current_cmp_o,
    output wire logic [5:0] pin_o
);
    // released outputs are pulled low at the gate driver inputs
    assign pin_o = motor_output_i & ~motor_output_oe_n_i;
    // alarm lines switch with a small driver delay, off any clock edge
    assign #1 emergency_stop_n_o = !alarm_i;
    assign #1 voltage_pwm_o = pwm_level_i;
    assign #1 current_cmp_o = cmp_level_i;
endmodule

// file: mpom_top_asserts.sv
// concurrent checks on the motor phase output manager ports
`timescale 1ns/1ps
module mpom_top_asserts #(
    parameter [1:0] RESET_STATE = 2'h0
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // watched inputs
    input wire emergency_stop_n_i,
    input wire emergency_irq_mask_i,
    input wire emergency_flag_clr_i,
    input wire direct_access_i,
    input wire sensor_mode_bit_i,
    input wire on_time_sampling_bit_i,
    input wire [3:0] sample_delay_field_i,
    input wire preload_wr_i,
    input wire comm_event_i,
    input wire [5:0] channel_on_off_preload_i,
    // watched outputs
    input wire [5:0] motor_output_o,
    input wire [5:0] motor_output_oe_n_o,
    input wire main_output_enable_o,
    input wire emergency_flag_o,
    input wire emergency_irq_o,
    input wire motor_timer_clk_en_o,
    input wire zc_detect_window_o,
    input wire measurement_window_o,
    input wire [5:0] phase_o
);
    localparam [5:0] RST_OE = (RESET_STATE == 2'h0) ? 6'h3f : 6'h00;
    localparam [5:0] RST_VAL = (RESET_STATE == 2'h2) ? 6'h3f : 6'h00;
    logic [6:0] frc_cnt_ff;
    logic [5:0] wr_data_ff;
    wire forced = sensor_mode_bit_i | on_time_sampling_bit_i |
        (|sample_delay_field_i);

    // length of the current forced-zero stretch and last preload written
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frc_cnt_ff <= 7'h00;
            wr_data_ff <= 6'h00;
        end else begin
            if (!forced)
                frc_cnt_ff <= 7'h00;
            else if (frc_cnt_ff != 7'h7f)
                frc_cnt_ff <= frc_cnt_ff + 7'h01;
            if (preload_wr_i)
                wr_data_ff <= channel_on_off_preload_i;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_estop_force: assert property (!emergency_stop_n_i |->
        motor_output_oe_n_o == RST_OE && motor_output_o == RST_VAL)
        else $error("outputs not in reset state during emergency");
    chk_estop_disable: assert property (
        !emergency_stop_n_i [*3] |-> !main_output_enable_o)
        else $error("enable still set during emergency");
    chk_irq_on: assert property (
        (emergency_flag_o && emergency_irq_mask_i) [*3] |-> emergency_irq_o)
        else $error("unmasked emergency without interrupt");
    chk_irq_masked: assert property (
        !emergency_irq_mask_i [*2] |-> !emergency_irq_o)
        else $error("masked emergency raised interrupt");
    chk_flag_hold: assert property ($fell(emergency_flag_o) |->
        $past(emergency_flag_clr_i, 2) || $past(emergency_flag_clr_i, 3))
        else $error("emergency flag dropped without clear");
    chk_out_disabled: assert property (
        !main_output_enable_o && !$past(main_output_enable_o) |->
        motor_output_oe_n_o == RST_OE && motor_output_o == RST_VAL)
        else $error("outputs active with enable clear");
    chk_timer_gate: assert property (
        direct_access_i [*2] |-> !motor_timer_clk_en_o)
        else $error("timer clock running in direct access");
    chk_zc_gate: assert property (
        sensor_mode_bit_i [*2] |-> !zc_detect_window_o)
        else $error("zero-cross window open in sensor mode");
    chk_forced_zero: assert property (
        frc_cnt_ff > 7'd120 |-> !measurement_window_o)
        else $error("window open with off time forced to zero");
    chk_phase_load: assert property (
        preload_wr_i && !comm_event_i ##1
        comm_event_i && !preload_wr_i && !direct_access_i |->
        ##[2:3] phase_o == wr_data_ff)
        else $error("phase not loaded from preload on commutation");
    chk_da_commit: assert property (
        direct_access_i && preload_wr_i |=> ##[1:2] phase_o == wr_data_ff)
        else $error("direct write did not reach phase");
endmodule

bind mpom_top mpom_top_asserts #(.RESET_STATE(RESET_STATE))
    u_mpom_top_asserts (.sys_clk_i, .rst_i, .emergency_stop_n_i,
    .emergency_irq_mask_i, .emergency_flag_clr_i, .direct_access_i,
    .sensor_mode_bit_i, .on_time_sampling_bit_i, .sample_delay_field_i,
    .preload_wr_i, .comm_event_i, .channel_on_off_preload_i,
    .motor_output_o, .motor_output_oe_n_o, .main_output_enable_o,
    .emergency_flag_o, .emergency_irq_o, .motor_timer_clk_en_o,
    .zc_detect_window_o, .measurement_window_o, .phase_o);

// file: mpom_top_tb_top.sv
// self-checking testbench of the motor phase output manager
`timescale 1ns/1ps
module mpom_top_tb_top;
    logic sys_clk_i = 0, rst_i = 1, clk_run = 1, current_mode_i = 0;
    logic sensor_mode_bit_i = 0, on_time_sampling_bit_i = 0;
    logic [3:0] sample_delay_field_i = 0, window_rate_select_i = 0;
    logic [3:0] min_off_time_select_i = 0;
    logic [5:0] channel_on_off_preload_i = 0, channel_polarity_i = 0;
    logic [5:0] parity_group_i = 0;
    logic preload_wr_i = 0, z_to_c_pwm_steer_i = 0, d_to_z_pwm_steer_i = 0;
    logic demag_pwm_steer_i = 0, direct_access_i = 0, clock_enable_i = 0;
    logic main_output_enable_set_i = 0, main_output_enable_clr_i = 0;
    logic emergency_irq_mask_i = 0, emergency_flag_clr_i = 0;
    logic comm_event_i = 0, demag_event_i = 0, zero_cross_event_i = 0;
    logic alarm = 0, pwm_level = 1, cmp_level = 0;
    wire voltage_pwm_i, current_cmp_i, emergency_stop_n_i;
    wire [5:0] motor_output_o, motor_output_oe_n_o, phase_o, pin;
    wire main_output_enable_o, emergency_flag_o, emergency_irq_o;
    wire motor_timer_clk_en_o, measurement_window_o, zc_detect_window_o;
    wire [1:0] step_state_o;
    integer err_count = 0, samples_checked = 0, hi, lo, k;

    mpom_top u_mpom_top (.*);
    mpom_power_stage u_mpom_power_stage (.motor_output_i(motor_output_o),
        .motor_output_oe_n_i(motor_output_oe_n_o), .alarm_i(alarm),
        .pwm_level_i(pwm_level), .cmp_level_i(cmp_level),
        .emergency_stop_n_o(emergency_stop_n_i),
        .voltage_pwm_o(voltage_pwm_i), .current_cmp_o(current_cmp_i),
        .pin_o(pin));

    // clock can be parked low to show the emergency path needs none
    initial begin
        forever begin
            #2.5;
            if (clk_run) sys_clk_i = ~sys_clk_i;
        end
    end

    task cyc(input integer n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task write_pre(input [5:0] d);
        channel_on_off_preload_i = d;
        pulse(preload_wr_i);
    endtask
    // expected pins for phase oo, steering s and pwm level p
    function [5:0] eo(input [5:0] oo, input s, input p);
        reg [5:0] a;
        a = oo & (p ? 6'h3f : (parity_group_i ^ {6{s}}));
        eo = ~(a ^ channel_polarity_i);
    endfunction
    task meas(output integer h, output integer l);
        integer n;
        h = 0;
        l = 0;
        n = 0;
        while (measurement_window_o !== 1 && n < 20000) begin
            cyc(1);
            n++;
        end
        while (measurement_window_o === 1 && h < 20000) begin
            cyc(1);
            h++;
            if (h == 20) check(zc_detect_window_o, 1);
        end
        while (measurement_window_o !== 1 && l < 20000) begin
            cyc(1);
            l++;
        end
    endtask
    task count_hi(output integer c);
        c = 0;
        repeat (4200) begin
            cyc(1);
            c += (measurement_window_o === 1);
        end
    endtask
    task count_on(output integer c);
        c = 0;
        repeat (4000) begin
            cyc(1);
            c += (motor_output_o === eo(6'h12, 1, 1));
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #450_000;
        err_count++;
        results;
    end

    initial begin
        cyc(12);
        rst_i = 0;
        cyc(2);
        check(motor_output_oe_n_o, 6'h3f);
        check({phase_o, step_state_o, main_output_enable_o}, 0);
        $display("test reset done");
        channel_polarity_i = 6'h2a;
        parity_group_i = 6'h38;
        pulse(main_output_enable_set_i);
        write_pre(6'h15);
        pulse(comm_event_i);
        cyc(4);
        check(phase_o, 6'h15);
        check(step_state_o, 1);
        check(motor_output_oe_n_o, 0);
        check(motor_output_o, eo(6'h15, 0, 1));
        $display("test phase and polarity done");
        pwm_level = 0;
        demag_pwm_steer_i = 1;
        z_to_c_pwm_steer_i = 1;
        write_pre(6'h21);
        pulse(comm_event_i);
        cyc(4);
        check(motor_output_o, eo(6'h21, 1, 0));
        demag_pwm_steer_i = 0;
        cyc(3);
        check(motor_output_o, eo(6'h21, 1, 0));
        pulse(demag_event_i);
        cyc(4);
        check(step_state_o, 2);
        check(motor_output_o, eo(6'h21, 0, 0));
        pulse(zero_cross_event_i);
        cyc(4);
        check(step_state_o, 3);
        check(motor_output_o, eo(6'h21, 1, 0));
        pulse(comm_event_i);
        cyc(4);
        check(motor_output_o, eo(6'h21, 0, 0));
        $display("test steering done");
        direct_access_i = 1;
        clock_enable_i = 1;
        cyc(3);
        check(motor_timer_clk_en_o, 0);
        write_pre(6'h12);
        cyc(3);
        check(step_state_o, 1);
        check(phase_o, 6'h12);
        check(motor_output_o, eo(6'h12, 1, 0));
        pulse(demag_event_i);
        pulse(zero_cross_event_i);
        cyc(3);
        check(step_state_o, 1);
        direct_access_i = 0;
        demag_pwm_steer_i = 1;
        pulse(comm_event_i);
        cyc(3);
        check(motor_timer_clk_en_o, 1);
        $display("test direct access done");
        current_mode_i = 1;
        for (k = 0; k < 2; k++) begin
            window_rate_select_i = k[3:0];
            min_off_time_select_i = 4'(2 * k + 1);
            meas(hi, lo);
            meas(hi, lo);
            check(hi, 500 * (2 * k + 2));
            check(hi + lo, k ? 5000 : 4000);
        end
        window_rate_select_i = 0;
        for (k = 0; k < 3; k++) begin
            sensor_mode_bit_i = (k == 0);
            on_time_sampling_bit_i = (k == 1);
            sample_delay_field_i = (k == 2) ? 4'h3 : 4'h0;
            cyc(200);
            count_hi(hi);
            check(hi, 0);
        end
        sensor_mode_bit_i = 0;
        sample_delay_field_i = 0;
        min_off_time_select_i = 4'hf;
        cyc(200);
        count_hi(hi);
        check(hi, 0);
        check(motor_output_o, eo(6'h12, 0, 1));
        min_off_time_select_i = 4'h1;
        cmp_level = 1;
        cyc(4500);
        check(motor_output_o, eo(6'h12, 1, 0));
        count_on(hi);
        check(hi, 0);
        cmp_level = 0;
        cyc(4200);
        count_on(hi);
        check(hi, 3000);
        $display("test window done");
        emergency_irq_mask_i = 1;
        clk_run = 0;
        #20 alarm = 1;
        #3 check(motor_output_oe_n_o, 6'h3f);
        check(pin, 0);
        clk_run = 1;
        cyc(8);
        check({emergency_flag_o, emergency_irq_o}, 2'h3);
        check(main_output_enable_o, 0);
        pulse(main_output_enable_set_i);
        cyc(3);
        check(main_output_enable_o, 0);
        alarm = 0;
        cyc(5);
        check({emergency_flag_o, main_output_enable_o}, 2'h2);
        pulse(emergency_flag_clr_i);
        cyc(3);
        check(emergency_flag_o, 0);
        emergency_irq_mask_i = 0;
        alarm = 1;
        cyc(8);
        check({emergency_flag_o, emergency_irq_o}, 2'h2);
        alarm = 0;
        pulse(emergency_flag_clr_i);
        pulse(main_output_enable_set_i);
        cyc(3);
        check(main_output_enable_o, 1);
        pulse(main_output_enable_clr_i);
        cyc(3);
        check({main_output_enable_o, motor_output_oe_n_o}, 7'h3f);
        $display("test emergency done");
        results;
    end
endmodule
